/* design/gpc_pkg.sv */
// package: register map, field layout, reset values and encodings of the gpio port block
package gpc_pkg;

    // =====================================================================
    // geometry
    localparam int NPORT        = 8;
    localparam int NPIN         = 8;
    localparam int NBIT         = NPORT * NPIN;
    localparam int FABRIC_PORTS = 4;

    // =====================================================================
    // register offsets inside one port window, and window stride
    localparam logic [4:0] OFS_OUT   = 5'h00;
    localparam logic [4:0] OFS_STATE = 5'h04;
    localparam logic [4:0] OFS_MODE  = 5'h08;
    localparam logic [4:0] OFS_CFG   = 5'h0C;
    localparam logic [4:0] OFS_IE    = 5'h10;
    localparam logic [4:0] OFS_PEND  = 5'h14;
    localparam logic [4:0] OFS_SRC   = 5'h18;
    localparam int         PORT_LSB  = 5;

    // =====================================================================
    // configuration register fields
    localparam int CFG_INDIS_LSB  = 0;
    localparam int CFG_OUTDIS_LSB = 8;
    localparam int CFG_SLEW_LSB   = 16;
    localparam int CFG_LVTTL_BIT  = 24;
    localparam int CFG_HOLD_BIT   = 25;
    localparam int CFG_CKPIN_LSB  = 26;
    localparam int CFG_CKUSE_BIT  = 29;
    localparam logic [31:0] CFG_MASK = 32'h3FFF_FFFF;

    // =====================================================================
    // reset values
    localparam logic [7:0]  OUT_RST  = 8'h00;
    localparam logic [23:0] MODE_RST = 24'h00_0000;
    localparam logic [31:0] CFG_RST  = 32'h0000_0000;
    localparam logic [7:0]  IE_RST   = 8'h00;
    localparam logic [15:0] SRC_RST  = 16'h0000;

    // =====================================================================
    // per-pin drive modes
    typedef enum logic [2:0] {
        DM_OFF        = 3'b000,
        DM_INPUT      = 3'b001,
        DM_RES_PU     = 3'b010,
        DM_RES_PD     = 3'b011,
        DM_OPEN_DRAIN = 3'b100,
        DM_OPEN_SRC   = 3'b101,
        DM_STRONG     = 3'b110,
        DM_WEAK       = 3'b111
    } gpc_mode_t;

    // per-pin output source
    localparam logic [1:0] SRC_REG    = 2'h0;
    localparam logic [1:0] SRC_PERIPH = 2'h1;
    localparam logic [1:0] SRC_FABRIC = 2'h2;

endpackage

/* design/gpc_port_ctrl.sv */
// gpio port control: eight 8-pin ports, drive modes, hold, pin source matrix, apb registers
// =========================================================================
// How it works
// R1 - pins are grouped into eight ports of eight pins, each port handled as one register unit.
// R2 - during reset every pin has output, pulls and input buffer switched off.
// R3 - each port has an output data register and a read-only pin state register.
// R4 - a pin raises an interrupt condition only when its interrupt enable bit is set.
// R5 - the enabled pending flags of each port combine into one request line, eight in all.
// R6 - each pin takes one of eight drive modes from a 3-bit field.
// R7 - each port has one bit selecting cmos or lvttl input threshold.
// R8 - each pin has an input disable and an output disable, independent of each other.
// R9 - while hold is set the pin drive of a port is frozen at its last state.
// R10 - each pin has a slow slew select bit.
// R11 - a per-pin source select picks register data, peripheral output or fabric signal.
// R12 - peripheral signals connect only at their fixed pin index, never via the fabric.
// R13 - only ports 0 to 3 connect to the routing fabric, in both directions.
// R14 - the fabric-side capture register of a port ticks on fabric clock or a pin of that port.
// R15 - a pending flag stays set until software clears it; the request stays while any is set. Here only flags whose ie_q bit is set count.
// R16 - pin inputs pass a two-flop synchroniser before any clocked use.
//
// The register offsets and register access over APB were chosen for this implementation.
module gpc_port_ctrl (
    input  wire logic                   mclk,          // system clock, 40 MHz
    input  wire logic                   reset,         // async reset, active high
    input  wire logic                   psel,          // apb select
    input  wire logic                   penable,       // apb access phase
    input  wire logic                   pwrite,        // apb write
    input  wire logic [7:0]             paddr,         // apb byte address
    input  wire logic [31:0]            pwdata,        // apb write data
    output logic      [31:0]            prdata,        // apb read data
    output logic                        pready,        // apb ready
    output logic                        pslverr,       // apb error, unmapped offset
    input  wire logic [gpc_pkg::NBIT-1:0] pin_i,       // pin levels from pads
    output logic      [gpc_pkg::NBIT-1:0] pin_o,       // pad output level
    output logic      [gpc_pkg::NBIT-1:0] pin_oe,      // pad output enable
    output logic      [gpc_pkg::NBIT-1:0] pin_pu,      // pull-up enable
    output logic      [gpc_pkg::NBIT-1:0] pin_pd,      // pull-down enable
    output logic      [gpc_pkg::NBIT-1:0] pin_weak,    // pulls are weak strength
    output logic      [gpc_pkg::NBIT-1:0] pin_in_en,   // input buffer enable
    output logic      [gpc_pkg::NBIT-1:0] pin_slow,    // slow slew select
    output logic      [gpc_pkg::NPORT-1:0] port_lvttl, // lvttl threshold per port
    input  wire logic [gpc_pkg::NBIT-1:0] periph_o,    // peripheral outputs at fixed pins
    output logic      [gpc_pkg::NBIT-1:0] periph_i,    // synchronised pin state to peripherals
    input  wire logic [31:0]            fabric_o,      // fabric outputs for ports 0..3
    input  wire logic                   fabric_clk_en, // fabric clock tick
    output logic      [31:0]            fabric_i,      // captured pins of ports 0..3
    output logic      [gpc_pkg::NPORT-1:0] port_irq    // one request per port
);
    import gpc_pkg::*;

    // =====================================================================
    // drive decode: returns {oe, o, pu, pd, weak}
    function automatic logic [4:0] gpc_drive(input gpc_mode_t m, input logic v);
        unique case (m)
            DM_OFF, DM_INPUT: gpc_drive = 5'h00;
            DM_RES_PU:        gpc_drive = {~v, 1'b0, v, 1'b0, 1'b0};
            DM_RES_PD:        gpc_drive = {v, 1'b1, 1'b0, ~v, 1'b0};
            DM_OPEN_DRAIN:    gpc_drive = {~v, 1'b0, 3'b000};
            DM_OPEN_SRC:      gpc_drive = {v, 1'b1, 3'b000};
            DM_STRONG:        gpc_drive = {1'b1, v, 3'b000};
            DM_WEAK:          gpc_drive = {2'b00, v, ~v, 1'b1};
        endcase
    endfunction

    // =====================================================================
    // register state
    logic [NPORT-1:0][7:0]  out_q;
    logic [NPORT-1:0][23:0] mode_q;
    logic [NPORT-1:0][31:0] cfg_q;
    logic [NPORT-1:0][7:0]  ie_q;
    logic [NPORT-1:0][15:0] src_q;
    logic [NBIT-1:0]        pend_q;
    logic [NBIT-1:0]        pend_d;
    logic [NBIT-1:0]        sync1_q;
    logic [NBIT-1:0]        sync2_q;
    logic [NBIT-1:0]        state_q;
    logic [NBIT-1:0]        state_d;
    logic [NBIT-1:0]        pin_rise;
    logic [NBIT-1:0]        drv_v;
    logic [NBIT-1:0][4:0]   drv;
    logic                   ready_q;
    logic [2:0]             port_sel;
    logic [4:0]             reg_ofs;
    logic                   wr_en;
    logic                   ofs_ok;
    logic [31:0]            rd_d;

    // =====================================================================
    // apb slave: setup, one wait cycle, then the completing access cycle
    assign port_sel = paddr[7:PORT_LSB];
    assign reg_ofs  = paddr[PORT_LSB-1:0];
    assign ofs_ok   = (reg_ofs <= OFS_SRC) && (reg_ofs[1:0] == 2'b00);
    assign wr_en    = psel && penable && ready_q && pwrite && ofs_ok;

    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (reg_ofs)
            OFS_OUT:   rd_d = {24'h00_0000, out_q[port_sel]};
            OFS_STATE: rd_d = {24'h00_0000, state_q[port_sel*NPIN +: NPIN]};     // [R3]
            OFS_MODE:  rd_d = {8'h00, mode_q[port_sel]};
            OFS_CFG:   rd_d = cfg_q[port_sel];
            OFS_IE:    rd_d = {24'h00_0000, ie_q[port_sel]};
            OFS_PEND:  rd_d = {24'h00_0000, pend_q[port_sel*NPIN +: NPIN]};
            OFS_SRC:   rd_d = {16'h0000, src_q[port_sel]};
            default:   rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ready_q <= 1'b0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            ready_q <= psel && penable && !ready_q;
            pready  <= psel && penable && !ready_q;
            pslverr <= psel && penable && !ready_q && !ofs_ok;
            if (psel && penable && !ready_q) begin
                prdata <= (ofs_ok && !pwrite) ? rd_d : 32'h0000_0000;
            end
        end
    end

    // =====================================================================
    // software registers, one window per port
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int p = 0; p < NPORT; p++) begin
                out_q[p]  <= OUT_RST;
                mode_q[p] <= MODE_RST;                                       // [R2]
                cfg_q[p]  <= CFG_RST;
                ie_q[p]   <= IE_RST;
                src_q[p]  <= SRC_RST;
            end
        end else if (wr_en) begin
            unique case (reg_ofs)
                OFS_OUT:  out_q[port_sel]  <= pwdata[7:0];                   // [R3] [R1]
                OFS_MODE: mode_q[port_sel] <= pwdata[23:0];                  // [R6]
                OFS_CFG:  cfg_q[port_sel]  <= pwdata & CFG_MASK;             // [R7] [R8] [R10]
                OFS_IE:   ie_q[port_sel]   <= pwdata[7:0];                   // [R4]
                OFS_SRC:  src_q[port_sel]  <= pwdata[15:0];                  // [R11]
                default:  ;
            endcase
        end
    end

    // =====================================================================
    // pin source matrix and drive decode
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            for (int i = 0; i < NPIN; i++) begin
                drv_v[p*NPIN+i] = out_q[p][i];
                if (src_q[p][2*i +: 2] == SRC_PERIPH) begin
                    drv_v[p*NPIN+i] = periph_o[p*NPIN+i];                    // [R12]
                end else if (src_q[p][2*i +: 2] == SRC_FABRIC && p < FABRIC_PORTS) begin
                    drv_v[p*NPIN+i] = fabric_o[(p%FABRIC_PORTS)*NPIN+i];     // [R13] [R11]
                end
                drv[p*NPIN+i] = gpc_drive(gpc_mode_t'(mode_q[p][3*i +: 3]),
                                          drv_v[p*NPIN+i]);                  // [R6]
            end
        end
    end

    // =====================================================================
    // pad control flops, frozen while the port is held
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pin_oe     <= '0;                                                // [R2]
            pin_o      <= '0;
            pin_pu     <= '0;
            pin_pd     <= '0;
            pin_weak   <= '0;
            pin_in_en  <= '0;
            pin_slow   <= '0;
            port_lvttl <= '0;
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                if (!cfg_q[p][CFG_HOLD_BIT]) begin                           // [R9]
                    port_lvttl[p] <= cfg_q[p][CFG_LVTTL_BIT];                // [R7]
                    for (int i = 0; i < NPIN; i++) begin
                        pin_oe[p*NPIN+i]    <= drv[p*NPIN+i][4]
                                             && !cfg_q[p][CFG_OUTDIS_LSB+i]; // [R8]
                        pin_o[p*NPIN+i]     <= drv[p*NPIN+i][3];
                        pin_pu[p*NPIN+i]    <= drv[p*NPIN+i][2];
                        pin_pd[p*NPIN+i]    <= drv[p*NPIN+i][1];
                        pin_weak[p*NPIN+i]  <= drv[p*NPIN+i][0];
                        pin_in_en[p*NPIN+i] <= (mode_q[p][3*i +: 3] != DM_OFF)
                                             && !cfg_q[p][CFG_INDIS_LSB+i];  // [R8]
                        pin_slow[p*NPIN+i]  <= cfg_q[p][CFG_SLEW_LSB+i];     // [R10]
                    end
                end
            end
        end
    end

    // =====================================================================
    // input synchroniser and pin state
    assign state_d  = sync2_q & pin_in_en;
    assign pin_rise = state_d & ~state_q;
    assign periph_i = state_q;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sync1_q <= '0;
            sync2_q <= '0;
            state_q <= '0;
        end else begin
            sync1_q <= pin_i;                                                // [R16]
            sync2_q <= sync1_q;                                              // [R16]
            state_q <= state_d;
        end
    end

    // =====================================================================
    // fabric-side capture register, ports 0..3 only
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            fabric_i <= 32'h0000_0000;
        end else begin
            for (int p = 0; p < FABRIC_PORTS; p++) begin
                if (cfg_q[p][CFG_CKUSE_BIT]
                        ? pin_rise[p*NPIN + int'(cfg_q[p][CFG_CKPIN_LSB +: 3])]
                        : fabric_clk_en) begin                               // [R14]
                    fabric_i[p*NPIN +: NPIN] <= state_q[p*NPIN +: NPIN];     // [R13]
                end
            end
        end
    end

    // =====================================================================
    // interrupts: any enabled pin change sets a sticky flag, write one clears
    always_comb begin
        pend_d = pend_q;
        for (int p = 0; p < NPORT; p++) begin
            if (wr_en && reg_ofs == OFS_PEND && port_sel == 3'(p)) begin
                pend_d[p*NPIN +: NPIN] = pend_q[p*NPIN +: NPIN] & ~pwdata[7:0];
            end
            pend_d[p*NPIN +: NPIN] = pend_d[p*NPIN +: NPIN]
                | ((state_d[p*NPIN +: NPIN] ^ state_q[p*NPIN +: NPIN]) & ie_q[p]); // [R4] [R15]
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pend_q   <= '0;
            port_irq <= '0;
        end else begin
            pend_q <= pend_d;                                                // [R15]
            for (int p = 0; p < NPORT; p++) begin
                port_irq[p] <= |(pend_q[p*NPIN +: NPIN] & ie_q[p]);          // [R5] [R15]
            end
        end
    end

endmodule

/* tb/gpc_port_ctrl_assertions.sv */
// checker: bus handshake, reset, synchroniser and interrupt assertions of the gpio port block
module gpc_port_ctrl_chk (
    input wire logic                      mclk,       // system clock
    input wire logic                      reset,      // async reset, active high
    input wire logic                      psel,       // apb select
    input wire logic                      penable,    // apb access phase
    input wire logic                      pwrite,     // apb write
    input wire logic [31:0]               prdata,     // apb read data
    input wire logic                      pready,     // apb ready
    input wire logic                      pslverr,    // apb error
    input wire logic [gpc_pkg::NBIT-1:0]  pin_i,      // pad input levels
    input wire logic [gpc_pkg::NBIT-1:0]  pin_oe,     // pad output enable
    input wire logic [gpc_pkg::NBIT-1:0]  pin_pu,     // pull-up enable
    input wire logic [gpc_pkg::NBIT-1:0]  pin_pd,     // pull-down enable
    input wire logic [gpc_pkg::NBIT-1:0]  pin_in_en,  // input buffer enable
    input wire logic [gpc_pkg::NBIT-1:0]  pin_slow,   // slow slew select
    input wire logic [gpc_pkg::NPORT-1:0] port_lvttl, // lvttl threshold
    input wire logic [gpc_pkg::NBIT-1:0]  periph_i,   // synchronised pin state
    input wire logic [gpc_pkg::NPORT-1:0] port_irq    // port requests
);
    import gpc_pkg::*;
    wire logic wr_commit = psel && penable && pready && pwrite;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // =====================================================================
    // assertions
    chk_reset_pads: assert property ($fell(reset) |-> !(|{pin_oe, pin_pu, pin_pd, pin_in_en}))
        else $error("pads active after reset");
    chk_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("ready missing after one wait state");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_write_rdata: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data not zero on write");
    chk_sync_stable: assert property (($stable(pin_i) && !psel) [*4] |=> $stable(periph_i))
        else $error("pin state moved without pin change");
    chk_irq_sticky: assert property (|($past(port_irq) & ~port_irq) |-> $past(wr_commit, 2))
        else $error("request dropped without software write");
    chk_cfg_by_write: assert property ($changed({pin_slow, port_lvttl, pin_in_en}) |-> $past(wr_commit, 2))
        else $error("pad setting changed without write");
endmodule

/* tb/gpc_pad_model.sv */
// pad model: resolves every pin from drive, pulls and the board level
module gpc_pad_model (
    input  wire logic [gpc_pkg::NBIT-1:0] pin_o,   // driven level
    input  wire logic [gpc_pkg::NBIT-1:0] pin_oe,  // drive enable
    input  wire logic [gpc_pkg::NBIT-1:0] pin_pu,  // pull-up enable
    input  wire logic [gpc_pkg::NBIT-1:0] pin_pd,  // pull-down enable
    input  wire logic [gpc_pkg::NBIT-1:0] ext_lvl, // board level where nothing drives
    output logic      [gpc_pkg::NBIT-1:0] pin_lvl  // resolved pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    import gpc_pkg::*;
    always_comb begin
        for (int i = 0; i < NBIT; i++) begin
            pin_lvl[i] = pin_oe[i] ? pin_o[i] : pin_pu[i] ? 1'b1 : pin_pd[i] ? 1'b0 : ext_lvl[i];
        end
    end
endmodule

/* tb/test_gpio_port_control.sv */
// testbench: registers, drive modes, hold, source select and port requests
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end
module test_gpio_port_control;
    timeunit 1ns;
    timeprecision 1ps;
    import gpc_pkg::*;
    logic              mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, fabric_clk_en = 0;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0, fabric_o = 32'h0, prdata, fabric_i, rd;
    logic              pready, pslverr, err_seen;
    logic [NBIT-1:0]   pin_i, pin_o, pin_oe, pin_pu, pin_pd, pin_weak, pin_in_en, pin_slow, periph_i;
    logic [NBIT-1:0]   periph_o = '0, ext_lvl = '0;
    logic [NPORT-1:0]  port_lvttl, port_irq;
    logic [2:0]        m3;
    logic [7:0]        oe_tab [8] = '{8'h00, 8'h00, 8'h0F, 8'hF0, 8'h0F, 8'hF0, 8'hFF, 8'h00};
    int                error_cnt = 0, tests_run = 0;
    gpc_port_ctrl i_dut (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .pin_i, .pin_o, .pin_oe, .pin_pu, .pin_pd, .pin_weak, .pin_in_en, .pin_slow,
        .port_lvttl, .periph_o, .periph_i, .fabric_o, .fabric_clk_en, .fabric_i, .port_irq);
    gpc_pad_model i_pad (.pin_o, .pin_oe, .pin_pu, .pin_pd, .ext_lvl, .pin_lvl(pin_i));
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    // =====================================================================
    // tasks
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge mclk);
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            error_cnt++;
            report_and_stop();
        end
    endtask
    task automatic settle(int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic wait_irq();
        int n;
        for (n = 0; n < 20 && port_irq[0] !== 1'b1; n++) @(posedge mclk);
        if (n == 20) begin
            error_cnt++;
            report_and_stop();
        end
        #1;
    endtask
    // =====================================================================
    // main sequence
    initial begin
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        settle(1);
        `CHK({pin_oe, pin_in_en, pin_pu, pin_pd}, 256'h0)
        foreach (oe_tab[i]) begin
            apb(1'b0, {3'd5, 5'(i * 4)}, 32'h0);
            if (i < 7) `CHK(rd, 32'h0)
        end
        `CHK(err_seen, 1'b1)
        $display("test reset done");
        apb(1'b1, {3'd1, OFS_OUT}, 32'hF0);
        for (int m = 0; m < 8; m++) begin
            m3 = 3'(m);
            apb(1'b1, {3'd1, OFS_MODE}, {8'h00, {8{m3}}});
            settle(2);
            `CHK(pin_oe[15:8], oe_tab[m])
            `CHK(pin_weak[15:8], {8{m3 == 3'd7}})
        end
        apb(1'b1, {3'd1, OFS_MODE}, 32'hDB6DB6);
        apb(1'b1, {3'd1, OFS_CFG}, 32'h0155_0F00);
        settle(2);
        `CHK(pin_oe[15:8], 8'hF0)
        `CHK(pin_slow[15:8], 8'h55)
        `CHK(port_lvttl, 8'h02)
        apb(1'b1, {3'd1, OFS_CFG}, 32'h0355_0F00);
        apb(1'b1, {3'd1, OFS_OUT}, 32'h0F);
        settle(2);
        `CHK(pin_o[15:8], 8'hF0)
        apb(1'b1, {3'd1, OFS_CFG}, 32'h0);
        settle(2);
        `CHK({pin_oe[15:8], pin_o[15:8]}, 16'hFF0F)
        $display("test drive done");
        apb(1'b1, {3'd1, OFS_SRC}, 32'h9);
        for (int v = 0; v < 4; v++) begin
            @(posedge mclk);
            periph_o[9:8] <= {~v[1], v[0]};
            fabric_o[9:8] <= {v[1], ~v[0]};
            settle(2);
            `CHK(pin_o[9:8], 2'(v))
        end
        $display("test source done");
        apb(1'b1, {3'd0, OFS_MODE}, 32'h249249);
        @(posedge mclk);
        ext_lvl[0] <= 1'b1;
        settle(6);
        apb(1'b0, {3'd0, OFS_STATE}, 32'h0);
        `CHK(rd, 32'h01)
        `CHK(pin_in_en[7:0], 8'hFF)
        `CHK(port_irq, 8'h00)
        apb(1'b1, {3'd0, OFS_IE}, 32'h01);
        @(posedge mclk);
        ext_lvl[0] <= 1'b0;
        wait_irq();
        `CHK(port_irq, 8'h01)
        settle(10);
        `CHK(port_irq, 8'h01)
        apb(1'b1, {3'd0, OFS_PEND}, 32'h01);
        settle(2);
        `CHK(port_irq, 8'h00)
        @(posedge mclk);
        ext_lvl[3:0] <= 4'hA;
        settle(6);
        @(posedge mclk);
        fabric_clk_en <= 1'b1;
        @(posedge mclk);
        fabric_clk_en <= 1'b0;
        settle(2);
        `CHK(fabric_i[7:0], 8'h0A)
        `CHK(periph_i[7:0], 8'h0A)
        apb(1'b1, {3'd0, OFS_CFG}, 32'h2400_0000);
        @(posedge mclk);
        ext_lvl[3:0] <= 4'h8;
        settle(6);
        `CHK(fabric_i[7:0], 8'h0A)
        @(posedge mclk);
        ext_lvl[3:0] <= 4'hA;
        settle(6);
        `CHK(fabric_i[7:0], 8'h08)
        $display("test input done");
        report_and_stop();
    end
endmodule
bind gpc_port_ctrl gpc_port_ctrl_chk i_chk (.mclk, .reset, .psel, .penable, .pwrite, .prdata,
    .pready, .pslverr, .pin_i, .pin_oe, .pin_pu, .pin_pd, .pin_in_en, .pin_slow, .port_lvttl,
    .periph_i, .port_irq);
